// File: hdl/spinup_delay.v
// spinup_delay.v: counts a whole number of delay units before spin-up
// assumes: load is a one-cycle pulse on the core clock
module spinup_delay #(
  parameter UNIT_CYC = 400000000
) (
  input  wire       core_clk,   // core clock
  input  wire       arst_n,     // asynchronous reset, active low
  input  wire       clk_en,     // freezes the count while low
  input  wire       load,       // pulse: start a delay of units
  input  wire [3:0] units,      // number of delay units to wait
  output reg        busy,       // high while the delay runs
  output reg        done,       // one-cycle pulse when the delay ends
  output reg  [3:0] units_left  // whole units still to wait
);

  localparam [31:0] UNIT_LAST = UNIT_CYC - 1;

  reg [31:0] cyc_q;

  // a unit counter plus a cycle prescaler; zero units finish at once
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q      <= 32'h0000_0000;
      units_left <= 4'h0;
      busy       <= 1'b0;
      done       <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        cyc_q      <= 32'h0000_0000;
        units_left <= units;
        busy       <= (units != 4'h0);
        done       <= (units == 4'h0);
      end else if (busy) begin
        if (cyc_q == UNIT_LAST) begin
          cyc_q <= 32'h0000_0000;
          if (units_left == 4'h1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          units_left <= units_left - 4'h1;
        end else begin
          cyc_q <= cyc_q + 32'h0000_0001;
        end
      end
    end
  end

endmodule

// File: hdl/strap_map.vh
// strap_map.vh: register offsets, field positions, reset values and timing
// assumes: included by the strap loader design files on a 40 MHz core clock
`ifndef STRAP_MAP_VH
`define STRAP_MAP_VH

// clock rate and the delayed-start unit
`define CORE_CLK_HZ        40000000
`define DELAY_UNIT_S       10
`define DELAY_UNIT_CYC     (`DELAY_UNIT_S * `CORE_CLK_HZ)

// cycles allowed for the strap synchronisers to flush before sampling
`define SAMPLE_SETTLE_CYC  4'h4

// register offsets (byte addresses, one word each)
`define REG_STATUS         4'h0
`define REG_CONTROL        4'h4
`define REG_DELAY_LEFT     4'h8
`define REG_STRAP_RAW      4'hc

// status register fields
`define ST_WP_BIT          0
`define ST_DELAY_BIT       1
`define ST_HOST_BIT        2
`define ST_PAR_DIS_BIT     3
`define ST_TERM_BIT        4
`define ST_SAMPLED_BIT     5
`define ST_RUN_BIT         6
`define ST_MASTER_BIT      7
`define ST_STATE_LSB       8
`define ST_ID_LSB          12

// control register fields
`define CTL_MASTER_BIT     0
`define CTL_START_BIT      1
`define CTL_RESET_VAL      1'b0

`endif

// File: hdl/strap_option_spinup_control.v
// strap_option_spinup_control.v: jumper decoder and spindle start control
// assumes: strap and reference index pins are asynchronous and pass two
// flops; start_unit_req comes from command logic on core_clk
//
// Operation
// - write-protect strap fitted refuses writes to whole medium; absent allows
// - delayed-start strap waits ten seconds times target id before spin-up; ignored when host-start strap is also fitted
// - host-start strap keeps spindle stopped until a Start Unit command
// - without host-start strap spin up at power-on, delayed per strap
// - parity-disable strap turns off parity checking and parity error reports
// - terminator strap asserts on-board terminator enable; default deasserted
// - drive reference index when sync master, else treat it as input
// - one reference index line plus ground shared by all drives
`include "strap_map.vh"

module strap_option_spinup_control #(
  parameter DELAY_UNIT_CYC = `DELAY_UNIT_CYC
) (
  input  wire        core_clk,          // core clock, 40 MHz
  input  wire        arst_n,            // asynchronous reset, active low
  input  wire        clk_en,            // freezes all state while low
  input  wire        strap_wp,          // write-protect jumper fitted
  input  wire        strap_delay,       // delayed-start jumper fitted
  input  wire        strap_host_start,  // wait-for-host jumper fitted
  input  wire        strap_parity_dis,  // parity-disable jumper fitted
  input  wire        strap_term,        // terminator jumper fitted
  input  wire [3:0]  strap_id,          // target id jumpers, bit 0 first
  input  wire        start_unit_req,    // pulse: Start Unit command decoded
  input  wire        write_req,         // medium write request
  input  wire        index_src,         // local spindle index pulse
  input  wire        ref_index_i,       // reference index pin, input side
  input  wire [3:0]  reg_addr,          // register byte address
  input  wire [31:0] reg_wdata,         // register write data
  input  wire        reg_wr,            // write strobe
  input  wire        reg_rd,            // read strobe
  output reg  [31:0] reg_rdata,         // read data, cycle after reg_rd
  output reg         write_protect,     // whole medium write protected
  output reg         write_refused,     // pulse: write request refused
  output reg         parity_check_en,   // bus parity checking on
  output reg         parity_report_en,  // parity error reporting on
  output reg         term_en,           // on-board terminator enable
  output reg  [3:0]  target_id,         // decoded bus target id
  output reg         spindle_run,       // spindle motor start command
  output reg         ref_index_o,       // reference index pin, drive level
  output reg         ref_index_oe,      // reference index pin, drive enable
  output reg         ref_index_rx       // reference index seen from peers
);

  // spin-up sequencer states
  localparam [1:0] S_SAMPLE = 2'h0;
  localparam [1:0] S_HOST   = 2'h1;
  localparam [1:0] S_DELAY  = 2'h2;
  localparam [1:0] S_RUN    = 2'h3;

  wire [8:0] strap_sync_w;
  wire [3:0] units_left_w;
  wire       delay_done_w;
  wire       delay_busy_w;
  wire       ref_in_sync_w;

  reg  [3:0] settle_q;
  reg        sampled_q;
  reg        wp_q;
  reg        delay_q;
  reg        host_q;
  reg        par_dis_q;
  reg        term_q;
  reg  [3:0] id_q;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        load_q;
  reg        master_q;
  reg        sw_start_q;
  reg        start_seen_q;

  // all strap pins pass the same two-flop synchroniser
  strap_sync #(
    .WIDTH (9)
  ) u_strap_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .async_in ({strap_id, strap_term, strap_parity_dis,
                strap_host_start, strap_delay, strap_wp}),
    .sync_out (strap_sync_w)
  );

  // the reference index is a pin from peers, so it is synchronised too
  strap_sync #(
    .WIDTH (1)
  ) u_ref_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .async_in (ref_index_i),
    .sync_out (ref_in_sync_w)
  );

  // delay unit counter for the id-scaled start
  spinup_delay #(
    .UNIT_CYC (DELAY_UNIT_CYC)
  ) u_delay (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .load       (load_q),
    .units      (id_q),
    .busy       (delay_busy_w),
    .done       (delay_done_w),
    .units_left (units_left_w)
  );

  // status word, decoded once here and used by the read mux
  function [31:0] status_word;
    input       f_wp;
    input       f_delay;
    input       f_host;
    input       f_par_dis;
    input       f_term;
    input       f_sampled;
    input       f_run;
    input       f_master;
    input [1:0] f_state;
    input [3:0] f_id;
    begin
      status_word = 32'h0000_0000;
      status_word[`ST_WP_BIT]      = f_wp;
      status_word[`ST_DELAY_BIT]   = f_delay;
      status_word[`ST_HOST_BIT]    = f_host;
      status_word[`ST_PAR_DIS_BIT] = f_par_dis;
      status_word[`ST_TERM_BIT]    = f_term;
      status_word[`ST_SAMPLED_BIT] = f_sampled;
      status_word[`ST_RUN_BIT]     = f_run;
      status_word[`ST_MASTER_BIT]  = f_master;
      status_word[`ST_STATE_LSB+1:`ST_STATE_LSB] = f_state;
      status_word[`ST_ID_LSB+3:`ST_ID_LSB]       = f_id;
    end
  endfunction

  // sample straps once, after the synchronisers have flushed; the captured
  // values then ignore any jumper change until the next reset
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_q  <= 4'h0;
      sampled_q <= 1'b0;
      wp_q      <= 1'b0;
      delay_q   <= 1'b0;
      host_q    <= 1'b0;
      par_dis_q <= 1'b0;
      term_q    <= 1'b0;
      id_q      <= 4'h0;
    end else if (clk_en && !sampled_q) begin
      if (settle_q == `SAMPLE_SETTLE_CYC) begin
        sampled_q <= 1'b1;
        wp_q      <= strap_sync_w[0];
        delay_q   <= strap_sync_w[1];
        host_q    <= strap_sync_w[2];
        par_dis_q <= strap_sync_w[3];
        term_q    <= strap_sync_w[4];
        id_q      <= strap_sync_w[8:5];
      end else begin
        settle_q <= settle_q + 4'h1;
      end
    end
  end

  // control register: sync master select and a software start request;
  // the start bit is a write-one pulse and reads back as zero
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_q   <= `CTL_RESET_VAL;
      sw_start_q <= 1'b0;
    end else if (clk_en) begin
      sw_start_q <= 1'b0;
      if (reg_wr && reg_addr == `REG_CONTROL) begin
        master_q   <= reg_wdata[`CTL_MASTER_BIT];
        sw_start_q <= reg_wdata[`CTL_START_BIT];
      end
    end
  end

  // a start that lands before sampling completes is remembered, not lost
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (start_unit_req || sw_start_q) begin
        start_seen_q <= 1'b1;
      end else if (state_q == S_RUN) begin
        start_seen_q <= 1'b0;
      end
    end
  end

  // spin-up sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_SAMPLE: begin
        if (sampled_q) begin
          if (host_q) begin
            state_d = S_HOST;
          end else if (delay_q) begin
            state_d = S_DELAY;
          end else begin
            state_d = S_RUN;
          end
        end
      end
      S_HOST: begin
        if (start_seen_q || start_unit_req || sw_start_q) begin
          state_d = S_RUN;
        end
      end
      S_DELAY: begin
        if (delay_done_w) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        state_d = S_RUN;
      end
      default: begin
        state_d = S_SAMPLE;
      end
    endcase
  end

  // sequencer state and the one-cycle load of the delay counter
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_SAMPLE;
      load_q  <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      load_q  <= (state_q == S_SAMPLE) && (state_d == S_DELAY);
    end
  end

  // decoded option outputs, all registered
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_protect    <= 1'b0;
      write_refused    <= 1'b0;
      parity_check_en  <= 1'b1;
      parity_report_en <= 1'b1;
      term_en          <= 1'b0;
      target_id        <= 4'h0;
      spindle_run      <= 1'b0;
    end else if (clk_en) begin
      write_protect    <= wp_q;
      write_refused    <= write_req && wp_q;
      parity_check_en  <= !par_dis_q;
      parity_report_en <= !par_dis_q;
      term_en          <= term_q;
      target_id        <= id_q;
      spindle_run      <= (state_d == S_RUN);
    end
  end

  // reference index: one shared line with ground, daisy chained by peers;
  // only the master drives it, every other drive listens
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_index_o  <= 1'b0;
      ref_index_oe <= 1'b0;
      ref_index_rx <= 1'b0;
    end else if (clk_en) begin
      ref_index_oe <= master_q;
      ref_index_o  <= master_q && index_src;
      ref_index_rx <= !master_q && ref_in_sync_w;
    end
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_STATUS: begin
            reg_rdata <= status_word(wp_q, delay_q, host_q, par_dis_q,
                                     term_q, sampled_q, spindle_run,
                                     master_q, state_q, id_q);
          end
          `REG_CONTROL: begin
            reg_rdata <= {31'h0000_0000, master_q};
          end
          `REG_DELAY_LEFT: begin
            reg_rdata <= {27'h000_0000, delay_busy_w, units_left_w};
          end
          `REG_STRAP_RAW: begin
            reg_rdata <= {23'h00_0000, strap_sync_w};
          end
          default: begin
            reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

// File: hdl/strap_sync.v
// strap_sync.v: two-flop synchroniser for a group of asynchronous levels
// assumes: inputs are slow levels from pins; no bus coherency across bits
module strap_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk, // core clock
  input  wire             arst_n,   // asynchronous reset, active low
  input  wire             clk_en,   // freezes the flops while low
  input  wire [WIDTH-1:0] async_in, // levels from outside the clock domain
  output wire [WIDTH-1:0] sync_out  // levels after two flops
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: test/peer_drive.sv
// peer_drive.sv: peer drives on the shared reference index line
// assumes: bench raises peer_on only while the block is not master
module peer_drive (
  input  wire logic core_clk,     // core clock
  input  wire logic peer_on,      // a peer master drives the line
  input  wire logic ref_index_o,  // block drive level
  input  wire logic ref_index_oe, // block drive enable
  output wire logic line          // resolved line level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q = 3'h0; // peer index phase, period 8
  logic       last_q = 1'b0;
  always @(posedge core_clk) begin
    ph_q <= ph_q + 3'h1;
    last_q <= line;
  end
  // one index line shared by all; a peer passes it down the chain
  // undriven line flips each cycle so a stale value never passes
  assign line = ref_index_oe ? (peer_on ? 1'bx : ref_index_o)
                             : (peer_on ? ph_q[2] : ~last_q);
endmodule

// File: test/strap_monitor.sv
// strap_monitor.sv: concurrent checks on the strap loader's top ports
// assumes: bound to strap_option_spinup_control; one clock, clk_en high
module strap_monitor (
  input wire logic        core_clk,         // core clock
  input wire logic        arst_n,           // async reset, active low
  input wire logic        clk_en,           // clock enable
  input wire logic        strap_host_start, // wait-for-host jumper
  input wire logic        start_unit_req,   // start command pulse
  input wire logic        write_req,        // medium write request
  input wire logic        index_src,        // local index
  input wire logic        reg_rd,           // read strobe
  input wire logic [31:0] reg_rdata,        // read data
  input wire logic        write_protect,    // write protect level
  input wire logic        write_refused,    // refused pulse
  input wire logic        parity_check_en,  // parity check on
  input wire logic        parity_report_en, // parity report on
  input wire logic        term_en,          // terminator enable
  input wire logic [3:0]  target_id,        // decoded id
  input wire logic        spindle_run,      // spindle start
  input wire logic        ref_index_o,      // index drive level
  input wire logic        ref_index_oe,     // index drive enable
  input wire logic        ref_index_rx      // index from peers
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q; // edges since release; settings sit still once it tops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 4'h0;
    else if (clk_en && cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    strap_host_start && start_unit_req && cnt_q == 4'hf;
  endsequence
  sequence s_run_soon;
    ##[1:4] spindle_run;
  endsequence
  AST_REFUSE: assert property (
    write_req && write_protect |=> write_refused)
    else $error("write while protected not refused");
  AST_REFUSE_CAUSE: assert property (
    write_refused |-> $past(write_req && write_protect))
    else $error("write refused without cause");
  AST_PARITY_PAIR: assert property (
    parity_check_en == parity_report_en)
    else $error("parity check and report differ");
  AST_RESET_VALS: assert property (
    cnt_q < 4'h4 |-> parity_check_en && !term_en && !write_protect
                     && !spindle_run && target_id == 4'h0)
    else $error("settings moved before strap sample");
  AST_SETTLED: assert property (
    cnt_q == 4'hf |-> $stable(write_protect) && $stable(target_id)
                      && $stable(term_en) && $stable(parity_check_en))
    else $error("settings changed after sampling");
  AST_RUN_HOLD: assert property (
    spindle_run |=> spindle_run)
    else $error("spindle stopped without reset");
  AST_START_UNIT: assert property (
    s_start |-> s_run_soon)
    else $error("start command did not spin up");
  AST_IDX_DRIVE: assert property (
    ref_index_o == (ref_index_oe && $past(index_src)))
    else $error("index drive level wrong");
  AST_RX_QUIET: assert property (
    ref_index_oe && $past(ref_index_oe) |-> !ref_index_rx)
    else $error("master still receives index");
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule

bind strap_option_spinup_control strap_monitor u_mon (
  .core_clk, .arst_n, .clk_en, .strap_host_start, .start_unit_req,
  .write_req, .index_src, .reg_rd, .reg_rdata, .write_protect,
  .write_refused, .parity_check_en, .parity_report_en, .term_en,
  .target_id, .spindle_run, .ref_index_o, .ref_index_oe, .ref_index_rx);

// File: test/testbench.sv
// testbench.sv: scenarios for the strap loader and spin-up control
// assumes: strap_map.vh on the include path; delay unit shortened to 20
`include "strap_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 20;
  logic core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
  logic strap_wp = 0, strap_delay = 0, strap_host_start = 0;
  logic strap_parity_dis = 0, strap_term = 0, peer_on = 0;
  logic start_unit_req = 0, write_req = 0, index_src = 0;
  logic reg_wr = 0, reg_rd = 0, ref_index_i;
  logic [3:0] strap_id = 4'h0, reg_addr = 4'h0, target_id, h;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
  logic write_protect, write_refused, parity_check_en, parity_report_en;
  logic term_en, spindle_run, ref_index_o, ref_index_oe, ref_index_rx;
  int num_errors = 0, samples_checked = 0;

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) index_src <= ~index_src;

  strap_option_spinup_control #(.DELAY_UNIT_CYC(UNIT)) u_dut (
    .core_clk, .arst_n, .clk_en, .strap_wp, .strap_delay,
    .strap_host_start, .strap_parity_dis, .strap_term, .strap_id,
    .start_unit_req, .write_req, .index_src, .ref_index_i, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .write_protect,
    .write_refused, .parity_check_en, .parity_report_en, .term_en,
    .target_id, .spindle_run, .ref_index_o, .ref_index_oe, .ref_index_rx);
  peer_drive u_peer (.core_clk, .peer_on, .ref_index_o, .ref_index_oe,
    .line(ref_index_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // straps are set while reset is low; they are read once after release
  task automatic boot(input logic [8:0] s, input int w);
    @(posedge core_clk);
    arst_n <= 1'b0;
    {strap_id, strap_term, strap_parity_dis, strap_host_start,
     strap_delay, strap_wp} <= s;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (w) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic wreq();
    @(posedge core_clk);
    write_req <= 1'b1;
    @(posedge core_clk);
    write_req <= 1'b0;
    #1;
  endtask
  task automatic t_defaults();
    boot({4'h5, 5'b00000}, 16);
    check(write_protect, 1'b0);
    check({parity_check_en, parity_report_en}, 2'b11);
    check(term_en, 1'b0);
    check(target_id, 4'h5);
    check(spindle_run, 1'b1);
    wreq();
    check(write_refused, 1'b0);
    rd(`REG_STATUS);
    check(rd_q, 32'h5360);
    rd(4'h2); // unmapped place reads zero
    check(rd_q, 32'h0);
    $display("defaults done");
  endtask
  task automatic t_fitted();
    boot({4'ha, 5'b11001}, 16);
    repeat (2) begin
      check(write_protect, 1'b1);
      check({parity_check_en, parity_report_en}, 2'b00);
      check(term_en, 1'b1);
      check(target_id, 4'ha);
      wreq();
      check(write_refused, 1'b1);
      @(posedge core_clk);
      {strap_id, strap_term, strap_parity_dis, strap_wp} <= 7'h05;
      repeat (12) @(posedge core_clk);
      #1;
    end
    // live straps moved, the captured settings must not have
    rd(`REG_STRAP_RAW);
    check(rd_q, 32'h011);
    rd(`REG_STATUS);
    check(rd_q, 32'ha379);
    $display("fitted straps done");
  endtask
  // time from release to spin-up must scale with the id
  task automatic t_delay(input logic [3:0] id);
    int n;
    n = 0;
    boot({id, 5'b00010}, 0);
    while (spindle_run !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(n >= id * UNIT && n <= id * UNIT + 12, 1'b1);
    rd(`REG_DELAY_LEFT);
    check(rd_q, 32'h0);
    $display("delay id %0d done after %0d cycles", id, n);
  endtask
  task automatic t_host();
    boot({4'h2, 5'b00110}, 200);
    check(spindle_run, 1'b0);
    @(posedge core_clk);
    start_unit_req <= 1'b1;
    @(posedge core_clk);
    start_unit_req <= 1'b0;
    repeat (4) @(negedge core_clk);
    check(spindle_run, 1'b1);
    boot({4'h2, 5'b00100}, 100);
    check(spindle_run, 1'b0);
    wr(`REG_CONTROL, 32'h2);
    repeat (4) @(negedge core_clk);
    check(spindle_run, 1'b1);
    $display("host start done");
  endtask
  task automatic t_sync();
    boot({4'h1, 5'b00000}, 10);
    peer_on <= 1'b1;
    h = 4'h0;
    for (int k = 0; k < 40; k++) begin
      @(negedge core_clk);
      if (k > 2) check(ref_index_rx, h[2]);
      h = {h[2:0], ref_index_i};
    end
    @(posedge core_clk);
    peer_on <= 1'b0;
    wr(`REG_CONTROL, 32'h1);
    rd(`REG_CONTROL);
    check(rd_q, 32'h1);
    repeat (3) @(negedge core_clk);
    check({ref_index_oe, ref_index_rx}, 2'b10);
    // the line carries the index taken at the last rising edge
    check({ref_index_i, ref_index_o}, {2{~index_src}});
    wr(`REG_CONTROL, 32'h0);
    repeat (3) @(negedge core_clk);
    check(ref_index_oe, 1'b0);
    // a frozen core must ignore a master select write
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`REG_CONTROL, 32'h1);
    clk_en <= 1'b1;
    repeat (3) @(negedge core_clk);
    check(ref_index_oe, 1'b0);
    $display("sync link done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // cut a hang short at 8000 cycles, well beyond the expected nine hundred or so
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    t_defaults();
    t_fitted();
    t_delay(4'h0);
    t_delay(4'h3);
    t_delay(4'hf);
    t_host();
    t_sync();
    final_report();
  end
endmodule
